//--- shared/dcso_pkg.sv
// ============================================================
// dcso_pkg
// ============================================================
// Purpose : constants and carriers of the drive object bank
// Assumes : register indices map to byte address index*4
// Notes   : one name per number
package dcso_pkg;

    // ============================================================
    // bus geometry
    // ============================================================
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;

    // ============================================================
    // register indices (byte address = index * 4)
    // ============================================================
    localparam logic [15:0] IDX_FE_REACTION   = 16'h3700;
    localparam logic [15:0] IDX_EEPROM_SIZE   = 16'h4012;
    localparam logic [15:0] IDX_HW_CONFIG     = 16'h4013;
    localparam logic [15:0] IDX_COND_POWER    = 16'h4014;
    localparam logic [15:0] IDX_COND_LOGIC    = 16'h4114;
    localparam logic [15:0] IDX_COND_TEMP     = 16'h4214;
    localparam logic [15:0] IDX_SERIAL_NUMBER = 16'h4040;
    localparam logic [15:0] IDX_DEVICE_IDENT  = 16'h4041;
    localparam logic [15:0] IDX_ERROR_CODE    = 16'h603f;
    localparam logic [15:0] IDX_IRQ_STATUS    = 16'h4300;
    localparam logic [15:0] IDX_IRQ_MASK      = 16'h4301;

    // ============================================================
    // reset values
    // ============================================================
    localparam logic [15:0] RST_FE_REACTION = 16'hffff;
    localparam logic [31:0] RST_HW_CONFIG   = 32'h00000000;
    localparam logic [15:0] RST_ERROR_CODE  = 16'h0000;
    localparam logic [3:0]  RST_IRQ_MASK    = 4'h0;

    // ============================================================
    // following-error reaction codes
    // ============================================================
    localparam logic [15:0] FE_NO_REACTION = 16'hffff;
    localparam logic [15:0] FE_STOP_NOW    = 16'h0000;
    localparam logic [15:0] FE_SLOW_RAMP   = 16'h0001;
    localparam logic [15:0] FE_QUICK_RAMP  = 16'h0002;

    // ============================================================
    // event bits of status and mask
    // ============================================================
    localparam int EVT_N          = 4;
    localparam int EVT_NEW_ERROR  = 0;
    localparam int EVT_RO_WRITE   = 1;
    localparam int EVT_BAD_CODE   = 2;
    localparam int EVT_FOLLOW_ERR = 3;

    // ============================================================
    // carriers
    // ============================================================
    typedef struct packed {
        logic [31:0] power_supply_voltage_reading;
        logic [31:0] logic_supply_voltage_reading;
        logic [31:0] board_temperature_reading;
    } dcso_cond_s;

    typedef struct packed {
        logic stop_now;
        logic brake_slow;
        logic brake_quick;
    } dcso_brake_s;

endpackage

//--- core/dcso_sync.sv
// ============================================================
// dcso_sync
// ============================================================
// Purpose : two-flop synchroniser for asynchronous levels
// Assumes : inputs are quasi-static levels
// Notes   : first stage read only by the second
`timescale 1ns/100ps
module dcso_sync
    import dcso_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

//--- core/dcso_irq.sv
// ============================================================
// dcso_irq
// ============================================================
// Purpose : sticky event status, write-one-to-clear, masked irq
// Assumes : set and clear arrive on mclk
// Notes   : a set in the clearing cycle wins
`timescale 1ns/100ps
module dcso_irq
    import dcso_pkg::*;
#(
    parameter int N = EVT_N
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [N-1:0] evt_set,
    input  wire logic         clr_wr,
    input  wire logic [N-1:0] clr_bits,
    input  wire logic [N-1:0] mask,
    output logic      [N-1:0] status,
    output logic              irq
);
    logic [N-1:0] next_status;

    always_comb begin
        next_status = (status & ~(clr_wr ? clr_bits : '0)) | evt_set;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & mask);
        end
    end
endmodule

//--- core/dcso_top.sv
// ============================================================
// dcso_top
// ============================================================
// Purpose : drive configuration and status object bank on APB
// Assumes : readings, eeprom size and error history come from
//           logic on mclk; the following-error flag is a pin
// Notes   : pready comes one cycle into the access phase
`timescale 1ns/100ps

// Functional notes
// - A signed 16-bit reaction selector holds -1 none, 0 stop, 1 slow ramp, 2 quick ramp; other codes are reserved.
// - The eeprom capacity in bytes reads as a read-only 32-bit value, zero meaning no eeprom.
// - The supply voltage in millivolts reads as a signed 32-bit value at the first conditions sub-entry.
// - The logic voltage in millivolts reads as a signed 32-bit value at the second conditions sub-entry.
// - The board temperature in tenths of a degree reads as a signed 32-bit value at the third sub-entry.
// - A read-only error code holds the code of the most recent error.
// - The error code equals the low 16 bits of the newest error-history entry.
// - The serial number is a read-only string that the host cannot change.
// - The device identity is a read-only byte string that the host cannot change.
module dcso_top
    import dcso_pkg::*;
#(
    parameter logic [31:0] SERIAL_STRING = 32'h30303031,  // arbitrary value
    parameter logic [31:0] DEVICE_STRING = 32'h44525631   // arbitrary value
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // sources on mclk
    input  wire logic [31:0]       eeprom_size_bytes,
    input  wire dcso_cond_s        cond_in,
    input  wire logic [31:0]       error_history_newest,
    input  wire logic              error_history_push,
    // pin
    input  wire logic              following_error_pin,
    // outputs
    output dcso_brake_s            brake_cmd,
    output logic [31:0]            hw_config,
    output logic                   irq
);

    // ============================================================
    // state
    // ============================================================
    logic [15:0]        fe_reaction;
    logic [15:0]        error_code;
    logic [EVT_N-1:0]   irq_mask;
    logic [EVT_N-1:0]   irq_status;
    logic [EVT_N-1:0]   evt_set;
    logic [31:0]        eeprom_size;
    dcso_cond_s         cond;
    logic               fe_level;
    logic               fe_level_d;
    logic               fe_rise;

    // ============================================================
    // bus decode
    // ============================================================
    logic               setup_phase;
    logic               commit;
    logic [15:0]        idx;
    logic               aligned;
    logic [DATA_W-1:0]  rd_value;
    logic               hit;
    logic               hit_ro;
    logic               wr_reject;
    logic               code_bad;
    logic [DATA_W-1:0]  wr_merged;
    logic [DATA_W-1:0]  wr_old;

    assign setup_phase = psel & ~penable;
    assign commit      = psel & penable & pready;
    assign aligned     = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:18] == '0);
    assign idx         = paddr[17:2];

    // read mux, hit flags and old value for byte merging
    always_comb begin
        rd_value = '0;
        hit      = aligned;
        hit_ro   = 1'b0;
        wr_old   = '0;
        unique case (idx)
            IDX_FE_REACTION: begin
                rd_value = {{16{fe_reaction[15]}}, fe_reaction};
                wr_old   = {16'h0000, fe_reaction};
            end
            IDX_EEPROM_SIZE: begin
                rd_value = eeprom_size;
                hit_ro   = 1'b1;
            end
            IDX_HW_CONFIG: begin
                rd_value = hw_config;
                wr_old   = hw_config;
            end
            IDX_COND_POWER: begin
                rd_value = cond.power_supply_voltage_reading;
                hit_ro   = 1'b1;
            end
            IDX_COND_LOGIC: begin
                rd_value = cond.logic_supply_voltage_reading;
                hit_ro   = 1'b1;
            end
            IDX_COND_TEMP: begin
                rd_value = cond.board_temperature_reading;
                hit_ro   = 1'b1;
            end
            IDX_SERIAL_NUMBER: begin
                rd_value = SERIAL_STRING;
                hit_ro   = 1'b1;
            end
            IDX_DEVICE_IDENT: begin
                rd_value = DEVICE_STRING;
                hit_ro   = 1'b1;
            end
            IDX_ERROR_CODE: begin
                rd_value = {16'h0000, error_code};
                hit_ro   = 1'b1;
            end
            IDX_IRQ_STATUS: begin
                rd_value = {{(DATA_W-EVT_N){1'b0}}, irq_status};
            end
            IDX_IRQ_MASK: begin
                rd_value = {{(DATA_W-EVT_N){1'b0}}, irq_mask};
                wr_old   = {{(DATA_W-EVT_N){1'b0}}, irq_mask};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (!aligned) begin
            rd_value = '0;
        end
    end

    // byte-lane merge of write data over the old contents
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_merged[8*b +: 8] = pstrb[b] ? pwdata[8*b +: 8] : wr_old[8*b +: 8];
        end
    end

    // a selector write outside the defined codes is refused
    always_comb begin
        unique case (wr_merged[15:0])
            FE_NO_REACTION, FE_STOP_NOW, FE_SLOW_RAMP, FE_QUICK_RAMP: code_bad = 1'b0;
            default: code_bad = 1'b1;
        endcase
    end

    assign wr_reject = pwrite & hit & (hit_ro | ((idx == IDX_FE_REACTION) & code_bad));

    // ============================================================
    // apb response
    // ============================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (setup_phase) begin
            pready  <= 1'b1;
            pslverr <= ~hit | wr_reject;
            prdata  <= pwrite ? '0 : rd_value;
        end else if (commit) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
    end

    // write strobe at the completing edge, only when accepted
    logic wr_ok;
    assign wr_ok = commit & pwrite & ~pslverr;

    // ============================================================
    // writable registers
    // ============================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fe_reaction <= RST_FE_REACTION;
        end else if (wr_ok && idx == IDX_FE_REACTION) begin
            fe_reaction <= wr_merged[15:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hw_config <= RST_HW_CONFIG;
        end else if (wr_ok && idx == IDX_HW_CONFIG) begin
            hw_config <= wr_merged;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_mask <= RST_IRQ_MASK;
        end else if (wr_ok && idx == IDX_IRQ_MASK) begin
            irq_mask <= wr_merged[EVT_N-1:0];
        end
    end

    // ============================================================
    // read-only sources, sampled so reads see a stable word
    // ============================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            eeprom_size <= '0;
            cond        <= '0;
        end else begin
            eeprom_size <= eeprom_size_bytes;
            cond        <= cond_in;
        end
    end

    // last error follows the newest history entry
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            error_code <= RST_ERROR_CODE;
        end else if (error_history_push) begin
            error_code <= error_history_newest[15:0];
        end
    end

    // ============================================================
    // following-error reaction
    // ============================================================
    dcso_sync #(
        .W (1)
    ) u_fe_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (following_error_pin),
        .sync_out (fe_level)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fe_level_d <= 1'b0;
        end else begin
            fe_level_d <= fe_level;
        end
    end

    assign fe_rise = fe_level & ~fe_level_d;

    // one-cycle brake command chosen by the selector
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            brake_cmd <= '0;
        end else begin
            brake_cmd.stop_now    <= fe_rise & (fe_reaction == FE_STOP_NOW);
            brake_cmd.brake_slow  <= fe_rise & (fe_reaction == FE_SLOW_RAMP);
            brake_cmd.brake_quick <= fe_rise & (fe_reaction == FE_QUICK_RAMP);
        end
    end

    // ============================================================
    // events and interrupt
    // ============================================================
    always_comb begin
        evt_set                 = '0;
        evt_set[EVT_NEW_ERROR]  = error_history_push;
        evt_set[EVT_RO_WRITE]   = commit & pwrite & pslverr & hit_ro;
        evt_set[EVT_BAD_CODE]   = commit & pwrite & pslverr & ~hit_ro & hit;
        evt_set[EVT_FOLLOW_ERR] = fe_rise;
    end

    dcso_irq #(
        .N (EVT_N)
    ) u_irq (
        .mclk     (mclk),
        .rst      (rst),
        .evt_set  (evt_set),
        .clr_wr   (wr_ok && idx == IDX_IRQ_STATUS),
        .clr_bits (wr_merged[EVT_N-1:0]),
        .mask     (irq_mask),
        .status   (irq_status),
        .irq      (irq)
    );

endmodule

//--- verif/dcso_checker.sv
// Purpose : concurrent checks on the ports of the object bank
// Assumes : byte address = index * 4; pready one cycle into access
// Notes   : reads are judged in the cycle pready stands
`timescale 1ns/100ps
module dcso_checker
    import dcso_pkg::*;
#(
    parameter logic [31:0] SERIAL_STRING = 32'h00000000,
    parameter logic [31:0] DEVICE_STRING = 32'h00000000
) (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [31:0]       eeprom_size_bytes,
    input wire dcso_cond_s        cond_in,
    input wire logic [31:0]       error_history_newest,
    input wire logic              error_history_push,
    input wire logic              following_error_pin,
    input wire dcso_brake_s       brake_cmd,
    input wire logic [31:0]       hw_config,
    input wire logic              irq
);
    localparam logic [19:0] A_EEP = {2'b00, IDX_EEPROM_SIZE, 2'b00};
    localparam logic [19:0] A_PWR = {2'b00, IDX_COND_POWER, 2'b00};
    localparam logic [19:0] A_TMP = {2'b00, IDX_COND_TEMP, 2'b00};
    localparam logic [19:0] A_SER = {2'b00, IDX_SERIAL_NUMBER, 2'b00};
    localparam logic [19:0] A_ERR = {2'b00, IDX_ERROR_CODE, 2'b00};
    localparam logic [19:0] A_HWC = {2'b00, IDX_HW_CONFIG, 2'b00};
    logic [15:0] last_code;
    logic        rd_now;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // ============================================================
    // last error code seen on the history port
    // ============================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_code <= RST_ERROR_CODE;
        end else if (error_history_push) begin
            last_code <= error_history_newest[15:0];
        end
    end
    assign rd_now = pready && !pwrite;

    pready_timing_a: assert property (psel && !penable |=> pready) else $error("pready late");
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    // read words pass the source flop and the prdata flop: two edges back
    eeprom_read_a: assert property (rd_now && paddr == A_EEP |-> prdata == $past(eeprom_size_bytes, 2))
        else $error("eeprom size read wrong");
    power_read_a: assert property (rd_now && paddr == A_PWR |->
        prdata == $past(cond_in.power_supply_voltage_reading, 2)) else $error("supply read wrong");
    temp_read_a: assert property (rd_now && paddr == A_TMP |->
        prdata == $past(cond_in.board_temperature_reading, 2)) else $error("temperature read wrong");
    serial_read_a: assert property (rd_now && paddr == A_SER |-> prdata == SERIAL_STRING)
        else $error("serial read wrong");
    error_code_a: assert property (rd_now && paddr == A_ERR |-> prdata[15:0] == $past(last_code))
        else $error("error code wrong");
    ro_refused_a: assert property (pready && pwrite && (paddr == A_EEP || paddr == A_SER) |-> pslverr)
        else $error("read-only write accepted");
    hwcfg_write_a: assert property (pready && pwrite && paddr == A_HWC && pstrb == 4'hf && !pslverr
        |=> hw_config == $past(pwdata)) else $error("config write lost");
    brake_pulse_a: assert property (brake_cmd != 3'h0 |-> $onehot(brake_cmd) ##1 brake_cmd == 3'h0)
        else $error("brake pulse malformed");
endmodule
bind dcso_top dcso_checker #(.SERIAL_STRING(SERIAL_STRING), .DEVICE_STRING(DEVICE_STRING)) chk_i (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eeprom_size_bytes(eeprom_size_bytes), .cond_in(cond_in), .error_history_newest(error_history_newest),
    .error_history_push(error_history_push), .following_error_pin(following_error_pin),
    .brake_cmd(brake_cmd), .hw_config(hw_config), .irq(irq));

//--- verif/dcso_host.sv
// Purpose : host side model speaking apb to the object bank
// Assumes : one transfer at a time
// Notes   : waits on pready with no assumed latency
`timescale 1ns/100ps
module dcso_host
    import dcso_pkg::*;
(
    input  wire logic              mclk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [DATA_W-1:0]      pwdata,
    output logic [3:0]             pstrb,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
    end
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

//--- verif/drive_config_status_objects_tb.sv
// Purpose : register-level regression of the object bank
// Assumes : host model drives apb; bench drives the sources
// Notes   : brake and irq seen at the ports
`timescale 1ns/100ps
module drive_config_status_objects_tb;
    import dcso_pkg::*;
    localparam logic [31:0] SER = 32'h53303031;  // arbitrary value
    localparam logic [31:0] DEV = 32'h49443031;  // arbitrary value
    logic              mclk, rst, psel, penable, pwrite, pready, pslverr, push, pin, irq, er;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, eeprom, newest, hwcfg, rd;
    logic [3:0]        pstrb;
    logic [2:0]        got;
    dcso_cond_s        cond;
    dcso_brake_s       brake;
    int                fails, checked, cyc;
    logic [15:0]       ro_idx [5] = '{IDX_EEPROM_SIZE, IDX_COND_POWER, IDX_COND_LOGIC, IDX_COND_TEMP, IDX_SERIAL_NUMBER};
    logic [31:0]       sel_val [4] = '{32'hffffffff, 32'h0, 32'h1, 32'h2};
    logic [2:0]        sel_brk [4] = '{3'b000, 3'b100, 3'b010, 3'b001};

    dcso_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dcso_top #(.SERIAL_STRING(SER), .DEVICE_STRING(DEV)) dut (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eeprom_size_bytes(eeprom), .cond_in(cond),
        .error_history_newest(newest), .error_history_push(push), .following_error_pin(pin),
        .brake_cmd(brake), .hw_config(hwcfg), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s);
        host.xfer(1'b1, {2'b00, idx, 2'b00}, d, s, rd, er);
    endtask
    task automatic rdr(input logic [15:0] idx);
        host.xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, 4'h0, rd, er);
    endtask
    task automatic tally_and_finish();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [31:0] ro_exp(input int i);
        logic [31:0] v [5];
        v = '{eeprom, cond[95:64], cond[63:32], cond[31:0], SER};
        return v[i];
    endfunction

    initial begin
        rst = 1'b1;
        pin = 1'b0;
        push = 1'b0;
        newest = 32'h0;
        eeprom = 32'h0;
        cond = {32'd24000, 32'hffffec78, 32'hffffff9c};
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rdr(IDX_FE_REACTION); chk(rd, 32'hffffffff);
        rdr(IDX_EEPROM_SIZE); chk(rd, 32'h0);
        rdr(IDX_HW_CONFIG); chk(rd, RST_HW_CONFIG);
        rdr(IDX_ERROR_CODE); chk({16'h0, rd[15:0]}, {16'h0, RST_ERROR_CODE});
        rdr(IDX_IRQ_MASK); chk({28'h0, rd[3:0]}, {28'h0, RST_IRQ_MASK});
        $display("test reset values done");
        eeprom <= 32'h00008000;
        for (int i = 0; i < 5; i++) begin
            rdr(ro_idx[i]); chk(rd, ro_exp(i));
            wr(ro_idx[i], 32'h5a5a5a5a, 4'hf); chk({31'h0, er}, 32'h1);
            rdr(ro_idx[i]); chk(rd, ro_exp(i));
        end
        wr(IDX_DEVICE_IDENT, 32'h0, 4'hf); chk({31'h0, er}, 32'h1);
        rdr(IDX_DEVICE_IDENT); chk(rd, DEV);
        $display("test read-only entries done");
        for (int i = 0; i < 4; i++) begin
            wr(IDX_FE_REACTION, sel_val[i], 4'hf); chk({31'h0, er}, 32'h0);
            rdr(IDX_FE_REACTION); chk(rd, sel_val[i]);
            got = 3'h0;
            pin <= 1'b1;
            repeat (8) begin
                @(posedge mclk);
                if (brake !== 3'h0) got = brake;
            end
            chk({29'h0, got}, {29'h0, sel_brk[i]});
            pin <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        wr(IDX_FE_REACTION, 32'h3, 4'hf); chk({31'h0, er}, 32'h1);
        wr(IDX_FE_REACTION, 32'hffff8000, 4'hf); chk({31'h0, er}, 32'h1);
        rdr(IDX_FE_REACTION); chk(rd, 32'h2);
        $display("test reaction selector done");
        newest <= 32'hdead0042;
        push <= 1'b1;
        @(posedge mclk);
        push <= 1'b0;
        rdr(IDX_ERROR_CODE); chk({16'h0, rd[15:0]}, 32'h42);
        wr(IDX_ERROR_CODE, 32'h0, 4'hf); chk({31'h0, er}, 32'h1);
        rdr(IDX_ERROR_CODE); chk({16'h0, rd[15:0]}, 32'h42);
        $display("test error code done");
        rdr(IDX_IRQ_STATUS); chk({28'h0, rd[3:0]}, 32'hf);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_MASK, 32'h1, 4'hf);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_STATUS, 32'h1, 4'hf);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        rdr(IDX_IRQ_STATUS); chk({28'h0, rd[3:0]}, 32'he);
        host.xfer(1'b0, 20'h00004, 32'h0, 4'h0, rd, er); chk({31'h0, er}, 32'h1);
        host.xfer(1'b0, 20'h4dc00, 32'h0, 4'h0, rd, er); chk({31'h0, er}, 32'h1);
        $display("test interrupts and decode done");
        // the config word lands at the completing edge; look one edge later
        wr(IDX_HW_CONFIG, 32'h12345678, 4'hf);
        @(posedge mclk);
        chk(hwcfg, 32'h12345678);
        wr(IDX_HW_CONFIG, 32'h000000ff, 4'h1);
        @(posedge mclk);
        chk(hwcfg, 32'h123456ff);
        rdr(IDX_HW_CONFIG); chk(rd, 32'h123456ff);
        $display("test configuration word done");
        tally_and_finish();
    end
endmodule
